// ---- inc/lsi_map.svh ----
// register addresses, field positions and reset values of the status block
// assumes 8-bit register port on both ends
`ifndef LSI_MAP_SVH
`define LSI_MAP_SVH

// device register map
`define LSI_ADDR_SUMMARY  8'h13
`define LSI_ADDR_STATUS0  8'h14
`define LSI_ADDR_MASK0    8'h19
`define LSI_ADDR_SYNCRT   8'h1d
`define LSI_NUM_STATUS    8'h04
`define LSI_NUM_LATCHED   8'h05

// bit classes over the 40 latched bits, status one in the low byte
`define LSI_COND_BITS     40'h0f_0f0f_0f0f
`define LSI_DOUBLE_BITS   40'h00_0300_0000
`define LSI_LOF_BIT       8
`define LSI_REGAIN_BIT    12

// data values
`define LSI_SEL_ALL       8'hff
`define LSI_ZERO_BYTE     8'h00
`define LSI_RST_BYTE      8'h00

// host controller command registers
`define LSI_HREG_CTRL     8'h00
`define LSI_HREG_STAT     8'h01
`define LSI_HREG_SUM      8'h02
`define LSI_HREG_RES0     8'h03
`define LSI_CTRL_AUTO     0
`define LSI_CTRL_LOAD     1
`define LSI_STAT_BUSY     0
`define LSI_STAT_DONE     1

`endif

// ---- inc/lsi_pkg.sv ----
// shared types of the status block: byte type and host sequencer states
// assumes the map header supplies all numbers
package lsi_pkg;

  typedef logic [7:0] lsi_byte_t;

  typedef enum logic [9:0] {
    HS_IDLE   = 10'h001,
    HS_SUM    = 10'h002,
    HS_SUMCAP = 10'h004,
    HS_MRD    = 10'h008,
    HS_MCAP   = 10'h010,
    HS_MCLR   = 10'h020,
    HS_SSEL   = 10'h040,
    HS_SRD    = 10'h080,
    HS_SCAP   = 10'h100,
    HS_REST   = 10'h200
  } lsi_hstate_t;

endpackage

// ---- inc/lsi_if.sv ----
// link between the status device and its servicing host
// assumes one clock shared by both ends; the bench supplies clk
`timescale 1ns/1ns

interface lsi_if (
  input wire logic clk  // shared system clock
);
  lsi_pkg::lsi_byte_t busAddr;   // register address
  lsi_pkg::lsi_byte_t busWdata;  // write data / select byte
  logic               busWr;     // write strobe, one cycle
  logic               busRd;     // read strobe, one cycle
  lsi_pkg::lsi_byte_t busRdata;  // read data, cycle after busRd
  logic               intReq;    // interrupt request, active high level

  modport dev (
    input  clk, busAddr, busWdata, busWr, busRd,
    output busRdata, intReq
  );
  modport host (
    input  clk, busRdata, intReq,
    output busAddr, busWdata, busWr, busRd
  );
endinterface

// ---- design/lsi_device.sv ----
// device end: latched status bits, masks, interrupt summary and request
// assumes status sources are logic on clk; the host follows write-then-read
// Notes on behaviour
// RQ1 - only masked status registers raise interrupts
// RQ2 - mask bit one lets status bit interrupt
// RQ3 - reset clears every writeable register
// RQ4 - status bit latches until host reads it
// RQ5 - event bit clears on read, sets again later
// RQ6 - condition bit stays set while condition persists
// RQ7 - host writes select byte before reading
// RQ8 - selected bits refresh readable copy, others hold
// RQ9 - host reads right after its select write
// RQ10 - double bits interrupt on condition start and end
// RQ11 - frame loss bit and regained-sync event bit
// RQ12 - information register latches but never interrupts
// RQ13 - realtime sync register is live, read-only
// RQ14 - summary at 13h shows interrupting status registers
// RQ15 - host reads summary first, then status registers
// RQ16 - host clears masks, restores them when done
// RQ17 - summary bit ORs masked bits, drives request
`timescale 1ns/1ns
`include "lsi_map.svh"

module lsi_device (
  input  wire logic        clk,          // 125 MHz system clock
  input  wire logic        sys_rst,      // async reset, active high
  lsi_if.dev               link,         // register port toward host
  input  wire logic [31:0] statusSrc,    // status sources, event pulses or condition levels
  input  wire logic        lossOfFrame,  // loss of frame condition level
  input  wire logic [7:0]  infoSrc,      // information register sources
  input  wire logic [7:0]  syncState     // live synchronizer state
);

  // ==========================================================
  // decode helpers
  function automatic logic inWindow(input lsi_pkg::lsi_byte_t a,
                                    input lsi_pkg::lsi_byte_t base,
                                    input lsi_pkg::lsi_byte_t n);
    inWindow = (a >= base) && (a < base + n);
  endfunction

  // ==========================================================
  // storage
  logic [39:0]        latched;
  logic [39:0]        readCopy;
  logic [39:0]        srcPrev;
  logic [31:0]        mask;
  lsi_pkg::lsi_byte_t rdData;
  logic               irq;

  wire  [39:0]        rawSrc;
  wire  [39:0]        srcVec;
  wire  [39:0]        dblVec;
  wire  [39:0]        setHit;
  wire  [39:0]        selVec;
  wire  [31:0]        next_mask;
  wire  [3:0]         summary;
  lsi_pkg::lsi_byte_t next_rdData;
  lsi_pkg::lsi_byte_t readMux;

  // ==========================================================
  // source shaping
  assign rawSrc = {infoSrc, statusSrc};
  assign dblVec = `LSI_DOUBLE_BITS;

  genvar i;
  generate
    for (i = 0; i < 40; i++) begin : g_src
      if (i == `LSI_LOF_BIT) begin : g_lof
        assign srcVec[i] = lossOfFrame;                           // see RQ11
      end else if (i == `LSI_REGAIN_BIT) begin : g_reg
        // sync regained is the falling edge of frame loss
        assign srcVec[i] = srcPrev[`LSI_LOF_BIT] & ~lossOfFrame;  // see RQ11
      end else begin : g_raw
        assign srcVec[i] = rawSrc[i];
      end
    end
  endgenerate

  // conditions set while present; double bits also on clearance
  assign setHit = srcVec | (dblVec & srcPrev & ~srcVec);          // see RQ6 see RQ10

  // ==========================================================
  // register decode
  wire                isSt   = inWindow(link.busAddr, `LSI_ADDR_STATUS0, `LSI_NUM_LATCHED);
  wire                isMk   = inWindow(link.busAddr, `LSI_ADDR_MASK0, `LSI_NUM_STATUS);
  wire                isSum  = (link.busAddr == `LSI_ADDR_SUMMARY);
  wire                isRt   = (link.busAddr == `LSI_ADDR_SYNCRT);
  wire  [2:0]         stOff  = 3'(link.busAddr - `LSI_ADDR_STATUS0);
  wire  [1:0]         mkOff  = 2'(link.busAddr - `LSI_ADDR_MASK0);

  genvar r;
  generate
    for (r = 0; r < 5; r++) begin : g_sel
      // select byte: ones pick bits to refresh and clear
      assign selVec[r*8 +: 8] = (link.busWr && isSt && stOff == 3'(r)) ? link.busWdata
                                                                        : `LSI_ZERO_BYTE;  // see RQ8
    end
    for (r = 0; r < 4; r++) begin : g_mask
      assign next_mask[r*8 +: 8] = (link.busWr && isMk && mkOff == 2'(r)) ? link.busWdata
                                                                          : mask[r*8 +: 8];
      // info register sits above bit 31 and has no mask
      assign summary[r] = |(latched[r*8 +: 8] & mask[r*8 +: 8]);  // see RQ1 see RQ2 see RQ12 see RQ17
    end
  endgenerate

  // ==========================================================
  // read path, data valid only in the cycle after the strobe
  assign readMux = isSt  ? readCopy[{stOff, 3'b000} +: 8] :
                   isMk  ? mask[{mkOff, 3'b000} +: 8]     :
                   isSum ? {4'h0, summary}                :   // see RQ14
                   isRt  ? syncState                      :   // see RQ13
                           `LSI_ZERO_BYTE;
  assign next_rdData = link.busRd ? readMux : `LSI_ZERO_BYTE;

  assign link.busRdata = rdData;
  assign link.intReq   = irq;

  // ==========================================================
  // state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      latched  <= '0;                                             // see RQ3
      readCopy <= '0;
      srcPrev  <= '0;
      mask     <= '0;
      rdData   <= `LSI_RST_BYTE;
      irq      <= 1'b0;
    end else begin
      srcPrev  <= srcVec;
      // a new set wins over the clear of a select write
      latched  <= setHit | (latched & ~selVec);                   // see RQ4 see RQ5
      readCopy <= (readCopy & ~selVec) | ((latched | setHit) & selVec);  // see RQ8
      mask     <= next_mask;
      rdData   <= next_rdData;
      irq      <= |summary;                                       // see RQ17
    end
  end

endmodule

// ---- design/lsi_host.sv ----
// host end: services the interrupt by summary, mask save, poll and restore
// assumes one shared clock with the device; software uses a plain command port
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`include "lsi_map.svh"

module lsi_host (
  input  wire logic        clk,        // 125 MHz system clock
  input  wire logic        sys_rst,    // async reset, active high
  lsi_if.host              link,       // register port toward device
  input  wire logic [7:0]  cmdAddr,    // command register address
  input  wire logic [7:0]  cmdWdata,   // command write data
  input  wire logic        cmdWr,      // command write strobe
  input  wire logic        cmdRd,      // command read strobe
  output      logic [7:0]  cmdRdata    // command read data, cycle after cmdRd
);

  // ==========================================================
  // helpers
  function automatic logic [1:0] lowIdx(input logic [3:0] p);
    lowIdx = p[0] ? 2'd0 : p[1] ? 2'd1 : p[2] ? 2'd2 : 2'd3;
  endfunction

  // ==========================================================
  // storage
  lsi_pkg::lsi_hstate_t state, next_state;
  logic [1:0]           idx, next_idx;
  logic [3:0]           pend, next_pend;
  logic [3:0]           sumCap;
  logic [31:0]          saved;
  logic [31:0]          result;
  logic                 autoEn;
  logic                 serviced;
  lsi_pkg::lsi_byte_t   busAddr, busWdata;
  logic                 busWr, busRd;

  wire lastIdx = (idx == 2'd3);
  // masks are staged in the save store and sent out by the restore run
  wire loadReq = cmdWr && (cmdAddr == `LSI_HREG_CTRL) && cmdWdata[`LSI_CTRL_LOAD];

  // ==========================================================
  // service sequencer
  always_comb begin
    next_state = state;
    next_idx   = idx;
    next_pend  = pend;
    unique case (state)
      lsi_pkg::HS_IDLE: begin
        if (loadReq) begin
          next_idx   = 2'd0;
          next_state = lsi_pkg::HS_REST;
        end else if (autoEn && link.intReq) begin
          next_state = lsi_pkg::HS_SUM;                           // see RQ15
        end
      end
      lsi_pkg::HS_SUM:    next_state = lsi_pkg::HS_SUMCAP;
      lsi_pkg::HS_SUMCAP: begin
        next_pend  = link.busRdata[3:0];
        next_idx   = 2'd0;
        next_state = lsi_pkg::HS_MRD;
      end
      lsi_pkg::HS_MRD:    next_state = lsi_pkg::HS_MCAP;
      lsi_pkg::HS_MCAP: begin
        next_idx   = idx + 2'd1;
        next_state = lastIdx ? lsi_pkg::HS_MCLR : lsi_pkg::HS_MRD;
      end
      lsi_pkg::HS_MCLR: begin
        next_idx = idx + 2'd1;
        if (lastIdx) begin
          if (pend != 4'h0) begin
            next_idx   = lowIdx(pend);
            next_state = lsi_pkg::HS_SSEL;
          end else begin
            next_state = lsi_pkg::HS_REST;
          end
        end
      end
      lsi_pkg::HS_SSEL: begin
        next_pend[idx] = 1'b0;
        next_state     = lsi_pkg::HS_SRD;                         // see RQ9
      end
      lsi_pkg::HS_SRD:    next_state = lsi_pkg::HS_SCAP;
      lsi_pkg::HS_SCAP: begin
        if (pend != 4'h0) begin
          next_idx   = lowIdx(pend);
          next_state = lsi_pkg::HS_SSEL;
        end else begin
          next_idx   = 2'd0;
          next_state = lsi_pkg::HS_REST;
        end
      end
      lsi_pkg::HS_REST: begin
        next_idx = idx + 2'd1;
        if (lastIdx) next_state = lsi_pkg::HS_IDLE;
      end
    endcase
  end

  // ==========================================================
  // bus drive, registered from the coming state
  wire goRd   = (next_state == lsi_pkg::HS_SUM) || (next_state == lsi_pkg::HS_MRD) ||
                (next_state == lsi_pkg::HS_SRD);
  wire goMk   = (next_state == lsi_pkg::HS_MRD) || (next_state == lsi_pkg::HS_MCLR) ||
                (next_state == lsi_pkg::HS_REST);
  wire goSel  = (next_state == lsi_pkg::HS_SSEL);                 // see RQ7
  wire goClr  = (next_state == lsi_pkg::HS_MCLR);                 // see RQ16
  wire goRest = (next_state == lsi_pkg::HS_REST);                 // see RQ16
  wire goWr   = goSel || goClr || goRest;
  lsi_pkg::lsi_byte_t next_busAddr;
  lsi_pkg::lsi_byte_t next_busWdata;
  assign next_busAddr  = (next_state == lsi_pkg::HS_SUM) ? `LSI_ADDR_SUMMARY :
                         goMk ? `LSI_ADDR_MASK0 + 8'(next_idx) : `LSI_ADDR_STATUS0 + 8'(next_idx);
  assign next_busWdata = goSel  ? `LSI_SEL_ALL :
                         goRest ? saved[{next_idx, 3'b000} +: 8] : `LSI_ZERO_BYTE;

  // ==========================================================
  // command port
  wire                isRes   = (cmdAddr >= `LSI_HREG_RES0) && (cmdAddr < `LSI_HREG_RES0 + 8'h04);
  wire  [1:0]         resOff  = 2'(cmdAddr - `LSI_HREG_RES0);
  wire                busy    = (state != lsi_pkg::HS_IDLE);
  wire                doneHit = (state == lsi_pkg::HS_REST) && lastIdx;
  wire                doneClr = cmdWr && (cmdAddr == `LSI_HREG_STAT) && cmdWdata[`LSI_STAT_DONE];
  lsi_pkg::lsi_byte_t cmdMux;
  assign cmdMux = (cmdAddr == `LSI_HREG_CTRL) ? {7'h00, autoEn}              :
                  (cmdAddr == `LSI_HREG_STAT) ? {6'h00, serviced, busy}      :
                  (cmdAddr == `LSI_HREG_SUM)  ? {4'h0, sumCap}               :
                  isRes                       ? result[{resOff, 3'b000} +: 8] : `LSI_ZERO_BYTE;

  assign link.busAddr  = busAddr;
  assign link.busWdata = busWdata;
  assign link.busWr    = busWr;
  assign link.busRd    = busRd;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= lsi_pkg::HS_IDLE;
      idx      <= 2'd0;
      pend     <= 4'h0;
      sumCap   <= 4'h0;
      saved    <= '0;
      result   <= '0;
      autoEn   <= 1'b0;
      serviced <= 1'b0;
      busAddr  <= `LSI_RST_BYTE;
      busWdata <= `LSI_RST_BYTE;
      busWr    <= 1'b0;
      busRd    <= 1'b0;
      cmdRdata <= `LSI_RST_BYTE;
    end else begin
      state    <= next_state;
      idx      <= next_idx;
      pend     <= next_pend;
      busAddr  <= next_busAddr;
      busWdata <= next_busWdata;
      busWr    <= goWr;
      busRd    <= goRd;
      cmdRdata <= cmdRd ? cmdMux : `LSI_ZERO_BYTE;
      if (state == lsi_pkg::HS_SUMCAP) sumCap <= link.busRdata[3:0];
      if (state == lsi_pkg::HS_MCAP) saved[{idx, 3'b000} +: 8] <= link.busRdata;
      // staging only while idle, so a pass in flight restores what it saved
      if (state == lsi_pkg::HS_IDLE && cmdWr && isRes) saved[{resOff, 3'b000} +: 8] <= cmdWdata;
      if (state == lsi_pkg::HS_SCAP) result[{idx, 3'b000} +: 8] <= link.busRdata;
      if (cmdWr && cmdAddr == `LSI_HREG_CTRL) autoEn <= cmdWdata[`LSI_CTRL_AUTO];
      // a finishing pass wins over a clear in the same cycle
      serviced <= doneHit | (serviced & ~doneClr);
    end
  end

endmodule

// ---- tb/lsi_link_props.sv ----
// concurrent checks on the device-host link of the status block
// assumes plain copies of one link's signals plus the shared clock and reset
`timescale 1ns/1ns

module lsi_link_props (
  input wire logic               clk,       // shared clock
  input wire logic               sys_rst,   // async reset, active high
  input wire lsi_pkg::lsi_byte_t busAddr,   // register address
  input wire lsi_pkg::lsi_byte_t busWdata,  // write data / select byte
  input wire logic               busWr,     // write strobe
  input wire logic               busRd,     // read strobe
  input wire lsi_pkg::lsi_byte_t busRdata,  // read data
  input wire logic               intReq     // interrupt request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // shadow of mask writes, last summary read
  logic [31:0] maskShadow;
  logic [3:0]  sumSeen;
  logic        sumRdLast;
  wire  [3:0]  maskLive  = {|maskShadow[31:24], |maskShadow[23:16], |maskShadow[15:8], |maskShadow[7:0]};
  wire         statusAcc = (busAddr >= 8'h14) && (busAddr <= 8'h17);
  wire         maskAcc   = (busAddr >= 8'h19) && (busAddr <= 8'h1c);
  wire  [1:0]  maskIdx   = 2'(busAddr - 8'h19);

  // masks can be read back as well, but the shadow is rebuilt from the writes alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      maskShadow <= 32'h0000_0000;
      sumSeen    <= 4'h0;
      sumRdLast  <= 1'b0;
    end else begin
      sumRdLast <= busRd && (busAddr == 8'h13);
      if (sumRdLast) begin
        sumSeen <= busRdata[3:0];
      end
      if (busWr && maskAcc) begin
        maskShadow[{maskIdx, 3'b000} +: 8] <= busWdata;
      end
    end
  end

  // ==========================================================
  // sequences and assertions
  sequence selWrite;
    busWr && statusAcc;
  endsequence
  sequence pollRead;
    busRd && (busAddr == $past(busAddr));
  endsequence
  sequence maskRun;
    busWr && busAddr == 8'h19 ##1 busWr && busAddr == 8'h1a ##1 busWr && busAddr == 8'h1b
      ##1 busWr && busAddr == 8'h1c;
  endsequence

  a_sel_then_read: assert property (selWrite |=> pollRead)
    else $error("status select not followed by its read");
  a_read_needs_sel: assert property (busRd && statusAcc |-> $past(busWr) && $past(busAddr) == busAddr)
    else $error("status read without select write");
  a_sel_all_bits: assert property (selWrite |-> busWdata == 8'hff)
    else $error("host select byte not all ones");
  a_sum_upper_zero: assert property (sumRdLast |-> busRdata[7:4] == 4'h0)
    else $error("summary unused bits set");
  a_sum_masked: assert property (sumRdLast |-> (busRdata[3:0] & ~$past(maskLive)) == 4'h0)
    else $error("summary bit with all mask bits zero");
  a_int_off_unmasked: assert property (maskLive == 4'h0 |=> !intReq)
    else $error("interrupt with every mask cleared");
  a_mask_clear_run: assert property (busWr && busAddr == 8'h19 |-> maskRun)
    else $error("mask writes not a full run");
  a_sum_read_first: assert property (busRd && busAddr == 8'h19 |-> $past(busRd, 2) && $past(busAddr, 2) == 8'h13)
    else $error("mask save not preceded by summary read");
  a_poll_only_active: assert property (busRd && statusAcc |-> sumSeen[busAddr[1:0]])
    else $error("status polled without summary bit");
endmodule

// ---- tb/tb_latched_status_interrupt_logic.sv ----
// self-checking bench: a host-device pair, plus a second device driven by the bench
// assumes the design files are compiled first; the bench is host on the second link
`timescale 1ns/1ns

module tb_latched_status_interrupt_logic;
  logic               clk;
  logic               sys_rst;
  logic [31:0]        statusSrc;
  logic               lossOfFrame;
  lsi_pkg::lsi_byte_t infoSrc;
  lsi_pkg::lsi_byte_t syncState;
  lsi_pkg::lsi_byte_t cmdAddr;
  lsi_pkg::lsi_byte_t cmdWdata;
  logic               cmdWr;
  logic               cmdRd;
  lsi_pkg::lsi_byte_t cmdRdata;
  int                 errors;
  int                 checks_done;

  lsi_if lk (.clk(clk));
  lsi_if lk2 (.clk(clk));
  lsi_device i_lsi_device (.clk(clk), .sys_rst(sys_rst), .link(lk), .statusSrc(statusSrc),
    .lossOfFrame(lossOfFrame), .infoSrc(infoSrc), .syncState(syncState));
  lsi_host i_lsi_host (.clk(clk), .sys_rst(sys_rst), .link(lk), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
    .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata));
  // a second device gives the bench direct register access
  lsi_device i_lsi_device_b (.clk(clk), .sys_rst(sys_rst), .link(lk2), .statusSrc(statusSrc),
    .lossOfFrame(lossOfFrame), .infoSrc(infoSrc), .syncState(syncState));
  lsi_link_props i_lsi_link_props (.clk(clk), .sys_rst(sys_rst), .busAddr(lk.busAddr), .busWdata(lk.busWdata),
    .busWr(lk.busWr), .busRd(lk.busRd), .busRdata(lk.busRdata), .intReq(lk.intReq));

  // ==========================================================
  // bus tasks and comparison
  task automatic chk(input lsi_pkg::lsi_byte_t seen, exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wrb(input lsi_pkg::lsi_byte_t a, d);
    @(posedge clk);
    lk2.busAddr  <= a;
    lk2.busWdata <= d;
    lk2.busWr    <= 1'b1;
    @(posedge clk);
    lk2.busWr <= 1'b0;
  endtask
  task automatic rdc(input lsi_pkg::lsi_byte_t a, exp, input string msg);
    @(posedge clk);
    lk2.busAddr <= a;
    lk2.busRd   <= 1'b1;
    @(posedge clk);
    lk2.busRd <= 1'b0;
    #1;
    chk(lk2.busRdata, exp, msg);
  endtask
  // keep masks the sources so a condition can end on the very select edge
  task automatic selrd(input lsi_pkg::lsi_byte_t a, sel, exp, input string msg, input logic [31:0] keep = '1);
    @(posedge clk);
    lk2.busAddr  <= a;
    lk2.busWdata <= sel;
    lk2.busWr    <= 1'b1;
    statusSrc    <= statusSrc & keep;
    @(posedge clk);
    lk2.busWr <= 1'b0;
    lk2.busRd <= 1'b1;
    @(posedge clk);
    lk2.busRd <= 1'b0;
    #1;
    chk(lk2.busRdata, exp, msg);
  endtask
  task automatic crdc(input lsi_pkg::lsi_byte_t a, exp, input string msg);
    @(posedge clk);
    cmdAddr <= a;
    cmdRd   <= 1'b1;
    @(posedge clk);
    cmdRd <= 1'b0;
    #1;
    chk(cmdRdata, exp, msg);
  endtask
  task automatic cwr(input lsi_pkg::lsi_byte_t a, d);
    @(posedge clk);
    cmdAddr  <= a;
    cmdWdata <= d;
    cmdWr    <= 1'b1;
    @(posedge clk);
    cmdWr <= 1'b0;
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    statusSrc[b] <= 1'b1;
    @(posedge clk);
    statusSrc[b] <= 1'b0;
  endtask
  task automatic seeint(input logic exp, input string msg);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, lk2.intReq}, {7'h00, exp}, msg);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      rdc(8'h19 + 8'(i), 8'h00, "mask after reset");
    end
    rdc(8'h13, 8'h00, "summary after reset");
    crdc(8'h01, 8'h00, "host status after reset");
  endtask
  task automatic t_event();
    for (int n = 0; n < 4; n++) begin
      pulse(8 * n + 5);
      seeint(1'b0, "unmasked event");
      wrb(8'h19 + 8'(n), 8'h20);
      seeint(1'b1, "masked event");
      rdc(8'h13, 8'(1 << n), "summary bit");
      selrd(8'h14 + 8'(n), 8'h20, 8'h20, "event read");
      seeint(1'b0, "event cleared");
      selrd(8'h14 + 8'(n), 8'h20, 8'h00, "event gone");
      wrb(8'h19 + 8'(n), 8'h00);
    end
  endtask
  task automatic t_select();
    pulse(5);
    pulse(6);
    selrd(8'h14, 8'h20, 8'h20, "one bit selected");
    selrd(8'h14, 8'h00, 8'h20, "nothing selected");
    selrd(8'h14, 8'h40, 8'h60, "other bit selected");
    selrd(8'h14, 8'hff, 8'h00, "all cleared");
  endtask
  task automatic t_cond();
    @(posedge clk);
    statusSrc[0] <= 1'b1;
    selrd(8'h14, 8'h01, 8'h01, "condition set");
    selrd(8'h14, 8'h01, 8'h01, "condition held");
    @(posedge clk);
    statusSrc[0] <= 1'b0;
    selrd(8'h14, 8'h01, 8'h01, "latched after end");
    selrd(8'h14, 8'h01, 8'h00, "condition gone");
  endtask
  task automatic t_frame();
    @(posedge clk);
    lossOfFrame <= 1'b1;
    selrd(8'h15, 8'h01, 8'h01, "frame lost");
    @(posedge clk);
    lossOfFrame <= 1'b0;
    selrd(8'h15, 8'h11, 8'h11, "sync regained");
    selrd(8'h15, 8'h11, 8'h00, "frame bits clear");
  endtask
  task automatic t_double();
    @(posedge clk);
    statusSrc[26:24] <= 3'b101;
    repeat (3) @(posedge clk);
    selrd(8'h17, 8'h05, 8'h05, "both conditions", 32'hfaff_ffff);
    selrd(8'h17, 8'h05, 8'h01, "clearing edge");
    selrd(8'h17, 8'h05, 8'h00, "double bit read");
  endtask
  task automatic t_info();
    for (int i = 0; i < 4; i++) begin
      wrb(8'h19 + 8'(i), 8'hff);
    end
    @(posedge clk);
    infoSrc <= 8'h80;
    @(posedge clk);
    infoSrc <= 8'h00;
    seeint(1'b0, "info never interrupts");
    selrd(8'h18, 8'hff, 8'h80, "info latched");
    for (int i = 0; i < 4; i++) begin
      wrb(8'h19 + 8'(i), 8'h00);
    end
  endtask
  task automatic t_misc();
    @(posedge clk);
    syncState <= 8'h5a;
    rdc(8'h1d, 8'h5a, "live sync state");
    wrb(8'h1d, 8'h00);
    syncState <= 8'ha5;
    rdc(8'h1d, 8'ha5, "live sync follows");
    wrb(8'h13, 8'hff);
    rdc(8'h13, 8'h00, "summary read only");
    rdc(8'h30, 8'h00, "unmapped read");
  endtask
  task automatic t_host();
    // stage mask two, then load all masks; the load run also raises done
    cwr(8'h04, 8'h80);
    cwr(8'h00, 8'h03);
    repeat (6) @(posedge clk);
    cwr(8'h01, 8'h02);
    crdc(8'h00, 8'h01, "auto service on");
    crdc(8'h01, 8'h00, "host idle, done cleared");
    // the second pass only interrupts if the first restored the mask
    for (int k = 0; k < 2; k++) begin
      pulse(15);
      repeat (3) @(posedge clk);
      crdc(8'h01, 8'h01, "host serving");
      repeat (25) @(posedge clk);
      #1;
      chk({7'h00, lk.intReq}, 8'h00, "pair link quiet after service");
      crdc(8'h01, 8'h02, "host done");
      crdc(8'h02, 8'h02, "summary captured");
      crdc(8'h04, 8'h80, "status two captured");
      cwr(8'h01, 8'h02);
    end
    selrd(8'h15, 8'hff, 8'h80, "bench device latched");
    selrd(8'h15, 8'hff, 8'h00, "bench device cleared");
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // the full sequence takes well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    statusSrc = 32'h0000_0000;
    lossOfFrame = 1'b0;
    infoSrc = 8'h00;
    syncState = 8'h00;
    cmdAddr = 8'h00;
    cmdWdata = 8'h00;
    cmdWr = 1'b0;
    cmdRd = 1'b0;
    lk2.busAddr = 8'h00;
    lk2.busWdata = 8'h00;
    lk2.busWr = 1'b0;
    lk2.busRd = 1'b0;
    errors = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_host();
    t_event();
    t_select();
    t_cond();
    t_frame();
    t_double();
    t_info();
    t_misc();
    give_verdict();
  end
endmodule
